// ### hdl/irq_ctrl_pkg.sv
// Constants for the two-level interrupt controller
package irq_ctrl_pkg;
   localparam int N_SRC = 9;
   // Source index in polling order, 0 polled first
   localparam int SRC_SUPPLY = 0;
   localparam int SRC_EXT0   = 1;
   localparam int SRC_CONV   = 2;
   localparam int SRC_TMR0   = 3;
   localparam int SRC_EXT1   = 4;
   localparam int SRC_TMR1   = 5;
   localparam int SRC_SERIAL = 6;
   localparam int SRC_UART   = 7;
   localparam int SRC_TMR2   = 8;
   // Primary enable register bit positions
   localparam int PE_GLOBAL = 7;
   localparam int PE_CONV   = 6;
   localparam int PE_TMR2   = 5;
   localparam int PE_UART   = 4;
   localparam int PE_TMR1   = 3;
   localparam int PE_EXT1   = 2;
   localparam int PE_TMR0   = 1;
   localparam int PE_EXT0   = 0;
   // Level select register bit positions
   localparam int LS_SERIAL = 7;
   localparam int LS_CONV   = 6;
   localparam int LS_TMR2   = 5;
   localparam int LS_UART   = 4;
   localparam int LS_TMR1   = 3;
   localparam int LS_EXT1   = 2;
   localparam int LS_TMR0   = 1;
   localparam int LS_EXT0   = 0;
   // Secondary enable register bit positions
   localparam int SE_SUPPLY = 1;
   localparam int SE_SERIAL = 0;
   // Reset values and secondary write mask
   localparam logic [7:0] PRIMARY_RST   = 8'h00;
   localparam logic [7:0] LEVEL_RST     = 8'h00;
   localparam logic [7:0] SECONDARY_RST = 8'h00;
   localparam logic [7:0] SECONDARY_MASK = 8'h03;
   // Vector addresses
   localparam logic [15:0] VEC_EXT0   = 16'h0003;
   localparam logic [15:0] VEC_TMR0   = 16'h000b;
   localparam logic [15:0] VEC_EXT1   = 16'h0013;
   localparam logic [15:0] VEC_TMR1   = 16'h001b;
   localparam logic [15:0] VEC_UART   = 16'h0023;
   localparam logic [15:0] VEC_TMR2   = 16'h002b;
   localparam logic [15:0] VEC_CONV   = 16'h0033;
   localparam logic [15:0] VEC_SERIAL = 16'h003b;
   localparam logic [15:0] VEC_SUPPLY = 16'h0043;
   localparam logic [15:0] VEC_NONE   = 16'h0000;
endpackage : irq_ctrl_pkg

// ### hdl/irq_poll_pick.sv
// Fixed-order picker: lowest set index wins, with its vector
`timescale 1ns/1ps
module irq_poll_pick (
   input  wire logic [8:0]  req,     // Requests in polling order
   output logic             found,   // Any request present
   output logic [3:0]       idx,     // Index of winner
   output logic [15:0]      vector   // Vector of winner
);
   always_comb begin
      found = 1'b0;
      idx   = 4'h0;
      for (int i = irq_ctrl_pkg::N_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            found = 1'b1;
            idx   = 4'(i);
         end
      end
      case (idx)
         4'h0:    vector = irq_ctrl_pkg::VEC_SUPPLY;
         4'h1:    vector = irq_ctrl_pkg::VEC_EXT0;
         4'h2:    vector = irq_ctrl_pkg::VEC_CONV;
         4'h3:    vector = irq_ctrl_pkg::VEC_TMR0;
         4'h4:    vector = irq_ctrl_pkg::VEC_EXT1;
         4'h5:    vector = irq_ctrl_pkg::VEC_TMR1;
         4'h6:    vector = irq_ctrl_pkg::VEC_SERIAL;
         4'h7:    vector = irq_ctrl_pkg::VEC_UART;
         4'h8:    vector = irq_ctrl_pkg::VEC_TMR2;
         default: vector = irq_ctrl_pkg::VEC_NONE;
      endcase
      if (!found) begin
         vector = irq_ctrl_pkg::VEC_NONE;
      end
   end
endmodule : irq_poll_pick

// ### hdl/two_level_interrupt_ctrl.sv
// Two-level interrupt controller with fixed polling order and fixed vectors
`timescale 1ns/1ps

// Notes on behaviour
// - Only sources with their own enable bit set may be forwarded.
// - Each source except the supply monitor has its own high or low level select bit; supply monitor is always low.
// - High-level request preempts a running low-level handler and nests.
// - Same-cycle requests of both levels: high level vectored first.
// - Same-level requests wait while a handler of that level runs.
// - Same-level ties polled: supply, ext0, conv, tmr0, ext1, tmr1, serial, uart, tmr2.
// - Core pushes PC then loads the vector; controller offers vector with request.
// - Vectors 0003 through 0043 hex in steps of eight per source.
// - Global gate is bit 7 of primary enable register; reset zero.
// - Primary bits 6..0: conv, tmr2, uart, tmr1, ext1, tmr0, ext0.
// - Level select bits 7..0: serial, conv, tmr2, uart, tmr1, ext1, tmr0, ext0.
// - Secondary enable: bit1 supply monitor, bit0 serial; others reserved zero.
module two_level_interrupt_ctrl (
   input  wire logic        ref_clk,              // 50 MHz clock
   input  wire logic        rst_n,                // Async reset, active low
   input  wire logic        clk_en,               // Freezes all state when low
   input  wire logic        supply_monitor_irq,   // Supply monitor request
   input  wire logic        ext_irq_0,            // External 0 request
   input  wire logic        ext_irq_1,            // External 1 request
   input  wire logic        converter_done_irq,   // Converter request
   input  wire logic        timer0_overflow,      // Timer 0 request
   input  wire logic        timer1_overflow,      // Timer 1 request
   input  wire logic        timer2_overflow,      // Timer 2 overflow
   input  wire logic        timer2_ext_flag,      // Timer 2 external flag
   input  wire logic        twowire_irq,          // Two-wire request
   input  wire logic        sync_serial_irq,      // Synchronous serial request
   input  wire logic        uart_rx_flag,         // UART receive flag
   input  wire logic        uart_tx_flag,         // UART transmit flag
   input  wire logic        primary_we,           // Write strobe, primary enable
   input  wire logic        level_we,             // Write strobe, level select
   input  wire logic        secondary_we,         // Write strobe, secondary enable
   input  wire logic [7:0]  wdata,                // Write data for strobes
   input  wire logic        irq_ack,              // Core accepts offered vector
   input  wire logic        irq_return,           // Core returns from handler
   output logic             irq_req,              // Vector request to core
   output logic [15:0]      irq_vector,           // Vector address offered
   output logic [3:0]       irq_source,           // Source index offered
   output logic             active_high,          // High-level handler running
   output logic             active_low,           // Low-level handler running
   output logic [7:0]       primary_enable_reg,   // Primary enable readback
   output logic [7:0]       level_select_reg,     // Level select readback
   output logic [7:0]       secondary_enable_reg  // Secondary enable readback
);

   // ------------------------------------------------------------
   // Request gathering
   // ------------------------------------------------------------
   logic [8:0] raw;
   logic [8:0] en;
   logic [8:0] lvl;
   logic [8:0] live;
   logic [8:0] hi_req;
   logic [8:0] lo_req;

   always_comb begin
      raw = '0;
      raw[irq_ctrl_pkg::SRC_SUPPLY] = supply_monitor_irq;
      raw[irq_ctrl_pkg::SRC_EXT0]   = ext_irq_0;
      raw[irq_ctrl_pkg::SRC_CONV]   = converter_done_irq;
      raw[irq_ctrl_pkg::SRC_TMR0]   = timer0_overflow;
      raw[irq_ctrl_pkg::SRC_EXT1]   = ext_irq_1;
      raw[irq_ctrl_pkg::SRC_TMR1]   = timer1_overflow;
      raw[irq_ctrl_pkg::SRC_SERIAL] = twowire_irq | sync_serial_irq;
      raw[irq_ctrl_pkg::SRC_UART]   = uart_rx_flag | uart_tx_flag;
      raw[irq_ctrl_pkg::SRC_TMR2]   = timer2_overflow | timer2_ext_flag;

      en = '0;
      en[irq_ctrl_pkg::SRC_SUPPLY] = secondary_enable_reg[irq_ctrl_pkg::SE_SUPPLY];
      en[irq_ctrl_pkg::SRC_EXT0]   = primary_enable_reg[irq_ctrl_pkg::PE_EXT0];
      en[irq_ctrl_pkg::SRC_CONV]   = primary_enable_reg[irq_ctrl_pkg::PE_CONV];
      en[irq_ctrl_pkg::SRC_TMR0]   = primary_enable_reg[irq_ctrl_pkg::PE_TMR0];
      en[irq_ctrl_pkg::SRC_EXT1]   = primary_enable_reg[irq_ctrl_pkg::PE_EXT1];
      en[irq_ctrl_pkg::SRC_TMR1]   = primary_enable_reg[irq_ctrl_pkg::PE_TMR1];
      en[irq_ctrl_pkg::SRC_SERIAL] = secondary_enable_reg[irq_ctrl_pkg::SE_SERIAL];
      en[irq_ctrl_pkg::SRC_UART]   = primary_enable_reg[irq_ctrl_pkg::PE_UART];
      en[irq_ctrl_pkg::SRC_TMR2]   = primary_enable_reg[irq_ctrl_pkg::PE_TMR2];

      // Supply monitor has no level bit; it always polls as low level
      lvl = '0;
      lvl[irq_ctrl_pkg::SRC_EXT0]   = level_select_reg[irq_ctrl_pkg::LS_EXT0];
      lvl[irq_ctrl_pkg::SRC_CONV]   = level_select_reg[irq_ctrl_pkg::LS_CONV];
      lvl[irq_ctrl_pkg::SRC_TMR0]   = level_select_reg[irq_ctrl_pkg::LS_TMR0];
      lvl[irq_ctrl_pkg::SRC_EXT1]   = level_select_reg[irq_ctrl_pkg::LS_EXT1];
      lvl[irq_ctrl_pkg::SRC_TMR1]   = level_select_reg[irq_ctrl_pkg::LS_TMR1];
      lvl[irq_ctrl_pkg::SRC_SERIAL] = level_select_reg[irq_ctrl_pkg::LS_SERIAL];
      lvl[irq_ctrl_pkg::SRC_UART]   = level_select_reg[irq_ctrl_pkg::LS_UART];
      lvl[irq_ctrl_pkg::SRC_TMR2]   = level_select_reg[irq_ctrl_pkg::LS_TMR2];

      live   = raw & en & {9{primary_enable_reg[irq_ctrl_pkg::PE_GLOBAL]}};
      hi_req = live & lvl;
      lo_req = live & ~lvl;
   end

   // ------------------------------------------------------------
   // Polling at each level
   // ------------------------------------------------------------
   logic        hi_found;
   logic        lo_found;
   logic [3:0]  hi_idx;
   logic [3:0]  lo_idx;
   logic [15:0] hi_vec;
   logic [15:0] lo_vec;

   irq_poll_pick u_hi (
      .req    (hi_req),
      .found  (hi_found),
      .idx    (hi_idx),
      .vector (hi_vec)
   );

   irq_poll_pick u_lo (
      .req    (lo_req),
      .found  (lo_found),
      .idx    (lo_idx),
      .vector (lo_vec)
   );

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [7:0]  next_primary;
   logic [7:0]  next_level;
   logic [7:0]  next_secondary;

   // Strobes only count on clock-enabled edges
   always_comb begin
      next_primary   = primary_enable_reg;
      next_level     = level_select_reg;
      next_secondary = secondary_enable_reg;
      if (primary_we) begin
         next_primary = wdata;
      end
      if (level_we) begin
         next_level = wdata;
      end
      if (secondary_we) begin
         // Reserved bits dropped so they always read back zero
         next_secondary = wdata & irq_ctrl_pkg::SECONDARY_MASK;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         primary_enable_reg   <= irq_ctrl_pkg::PRIMARY_RST;
         level_select_reg     <= irq_ctrl_pkg::LEVEL_RST;
         secondary_enable_reg <= irq_ctrl_pkg::SECONDARY_RST;
      end else if (clk_en) begin
         primary_enable_reg   <= next_primary;
         level_select_reg     <= next_level;
         secondary_enable_reg <= next_secondary;
      end
   end

   // ------------------------------------------------------------
   // Level state and offer
   // ------------------------------------------------------------
   // Requests are levels: a flag dropped before acceptance is withdrawn
   logic        next_active_high;
   logic        next_active_low;
   logic        next_irq_req;
   logic [15:0] next_irq_vector;
   logic [3:0]  next_irq_source;
   logic        offer_high;
   logic        next_offer_high;
   logic        take_hi;
   logic        take_lo;

   always_comb begin
      next_active_high = active_high;
      next_active_low  = active_low;

      // Return unwinds the innermost level first
      if (irq_return) begin
         if (active_high) begin
            next_active_high = 1'b0;
         end else begin
            next_active_low = 1'b0;
         end
      end
      // Level kept with the offer, so a later level write cannot mislabel it
      // Acceptance wins over a same-cycle return
      if (irq_ack && irq_req) begin
         if (offer_high) begin
            next_active_high = 1'b1;
         end else begin
            next_active_low = 1'b1;
         end
      end

      // Offer from the next active state so an accepted vector is not offered again
      take_hi = hi_found && !next_active_high;
      take_lo = lo_found && !next_active_high && !next_active_low;
      next_irq_req    = take_hi || take_lo;
      next_offer_high = take_hi;
      next_irq_vector = take_hi ? hi_vec : (take_lo ? lo_vec : irq_ctrl_pkg::VEC_NONE);
      next_irq_source = take_hi ? hi_idx : (take_lo ? lo_idx : 4'h0);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         active_high <= 1'b0;
         active_low  <= 1'b0;
         offer_high  <= 1'b0;
         irq_req     <= 1'b0;
         irq_vector  <= irq_ctrl_pkg::VEC_NONE;
         irq_source  <= 4'h0;
      end else if (clk_en) begin
         active_high <= next_active_high;
         active_low  <= next_active_low;
         offer_high  <= next_offer_high;
         irq_req     <= next_irq_req;
         irq_vector  <= next_irq_vector;
         irq_source  <= next_irq_source;
      end
   end

endmodule : two_level_interrupt_ctrl

// ### test/core_model.sv
// Core model: accepts offered vectors and keeps a return stack
`timescale 1ns/1ps
module core_model (
   input  wire logic        ref_clk,    // Clock
   input  wire logic        rst_n,      // Reset, active low
   input  wire logic        irq_req,    // Vector offered
   input  wire logic [15:0] irq_vector, // Offered vector
   input  wire logic        irq_return, // Handler finished
   input  wire logic [3:0]  ack_wait,   // Extra cycles before accept
   output logic             irq_ack,    // Accept pulse
   output logic [15:0]      pc          // Program counter
);
   logic [15:0] stack[$];
   int          cnt;
   // Wait lets the bench play a slow core
   always @(negedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt = 0;
         irq_ack <= 1'b0;
      end else begin
         cnt = (irq_req && !irq_ack) ? cnt + 1 : 0;
         irq_ack <= irq_req && !irq_ack && cnt > ack_wait;
      end
   end
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) pc <= 16'h0100;
      else if (irq_req && irq_ack) begin
         stack.push_back(pc);
         pc <= irq_vector;
      end else if (irq_return && stack.size() > 0) pc <= stack.pop_back();
   end
endmodule : core_model

// ### test/irq_ctrl_props.sv
// Checker for the two-level interrupt controller
`timescale 1ns/1ps
module irq_ctrl_props (
   input wire logic        ref_clk,             // Clock
   input wire logic        rst_n,               // Reset, active low
   input wire logic        clk_en,              // Advance enable
   input wire logic        primary_we,          // Primary strobe
   input wire logic [7:0]  wdata,               // Write data
   input wire logic        irq_ack,             // Core accept
   input wire logic        irq_return,          // Core return
   input wire logic        irq_req,             // Vector offered
   input wire logic [15:0] irq_vector,          // Offered vector
   input wire logic [3:0]  irq_source,          // Offered index
   input wire logic        active_high,         // High running
   input wire logic        active_low,          // Low running
   input wire logic [7:0]  primary_enable_reg,  // Primary enable
   input wire logic [7:0]  level_select_reg,    // Level select
   input wire logic [7:0]  secondary_enable_reg // Secondary enable
);
   localparam logic [15:0] VT [9] = '{16'h0043, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
                                      16'h001b, 16'h003b, 16'h0023, 16'h002b};
   logic [8:0] en;
   logic [8:0] hi;
   logic [7:0] p;
   logic [7:0] l;
   assign p  = primary_enable_reg;
   assign l  = level_select_reg;
   // Enable and level per polling index; supply monitor counts as low
   assign en = {p[5], p[4], secondary_enable_reg[0], p[3], p[2], p[1], p[6], p[0], secondary_enable_reg[1]};
   assign hi = {l[5], l[4], l[7], l[3], l[2], l[1], l[6], l[0], 1'b0};
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   property p_vec; irq_req |-> irq_vector == VT[irq_source]; endproperty
   a_vec: assert property (p_vec) else $error("offered vector wrong");
   property p_en; irq_req && $stable(p) && $stable(secondary_enable_reg) |-> en[irq_source] && p[7]; endproperty
   a_en: assert property (p_en) else $error("disabled source offered");
   property p_lvl; active_low && irq_req |-> hi[irq_source]; endproperty
   a_lvl: assert property (p_lvl) else $error("low request during low handler");
   property p_hblk; active_high |-> !irq_req; endproperty
   a_hblk: assert property (p_hblk) else $error("request during high handler");
   property p_ackh; irq_req && irq_ack && clk_en && hi[irq_source] |=> active_high && !irq_req; endproperty
   a_ackh: assert property (p_ackh) else $error("high accept not marked");
   // A high request arriving with the low accept may be offered at once
   property p_ackl; irq_req && irq_ack && clk_en && !hi[irq_source] |=> active_low && (!irq_req || hi[irq_source]);
   endproperty
   a_ackl: assert property (p_ackl) else $error("low accept not marked");
   property p_reth;
      irq_return && clk_en && active_high && !irq_ack |=> !active_high && active_low == $past(active_low);
   endproperty
   a_reth: assert property (p_reth) else $error("high return wrong");
   property p_retl; irq_return && clk_en && !active_high && active_low && !irq_ack |=> !active_low; endproperty
   a_retl: assert property (p_retl) else $error("low return wrong");
   property p_wr; primary_we && clk_en |=> p == $past(wdata); endproperty
   a_wr: assert property (p_wr) else $error("primary write lost");
   c_nest: cover property (active_low && active_high);
   c_reth: cover property (irq_return && active_high);
   c_wait: cover property (irq_req && active_low);
endmodule : irq_ctrl_props

// ### test/two_level_interrupt_ctrl_test.sv
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
module two_level_interrupt_ctrl_test;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] rq = 12'h000;
   logic [2:0]  we = 3'h0;
   logic [7:0]  wdata = 8'h00;
   logic [3:0]  ack_wait = 4'h0;
   logic        irq_return = 1'b0;
   logic        clk_en = 1'b1;
   logic [3:0]  irq_source;
   logic        irq_ack, irq_req, active_high, active_low;
   logic [15:0] irq_vector, pc;
   logic [7:0]  pe, ls, se;
   int          mismatches = 0;
   int          comparisons = 0;
   int          cycles = 0;
   always #10 ref_clk = ~ref_clk;
   two_level_interrupt_ctrl u_two_level_interrupt_ctrl (.ref_clk, .rst_n, .clk_en,
      .supply_monitor_irq(rq[0]), .ext_irq_0(rq[1]), .ext_irq_1(rq[2]), .converter_done_irq(rq[3]),
      .timer0_overflow(rq[4]), .timer1_overflow(rq[5]), .timer2_overflow(rq[6]), .timer2_ext_flag(rq[7]),
      .twowire_irq(rq[8]), .sync_serial_irq(rq[9]), .uart_rx_flag(rq[10]), .uart_tx_flag(rq[11]),
      .primary_we(we[0]), .level_we(we[1]), .secondary_we(we[2]), .wdata, .irq_ack, .irq_return,
      .irq_req, .irq_vector, .irq_source, .active_high, .active_low,
      .primary_enable_reg(pe), .level_select_reg(ls), .secondary_enable_reg(se));
   core_model u_core_model (.ref_clk, .rst_n, .irq_req, .irq_vector, .irq_return, .ack_wait, .irq_ack, .pc);
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(int sel, logic [7:0] d);
      @(negedge ref_clk);
      we[sel] = 1'b1;
      wdata = d;
      @(negedge ref_clk);
      we = 3'h0;
   endtask : wr
   // Waits for an offer, lets the core accept, then clears the source
   task automatic serve(logic [15:0] v, logic [11:0] m, logic hi, logic [3:0] s);
      for (int i = 0; i < 20 && irq_req !== 1'b1; i++) @(negedge ref_clk);
      chk("vector", v, irq_vector);
      chk("source", {12'h000, s}, {12'h000, irq_source});
      for (int i = 0; i < 20 && (hi ? active_high : active_low) !== 1'b1; i++) @(negedge ref_clk);
      chk("level marker", 16'h0001, {15'h0000, hi ? active_high : active_low});
      chk("core pc", v, pc);
      rq = rq & ~m;
   endtask : serve
   task automatic ret(logic h, logic l);
      irq_return = 1'b1;
      @(negedge ref_clk);
      irq_return = 1'b0;
      chk("high marker", {15'h0000, h}, {15'h0000, active_high});
      chk("low marker", {15'h0000, l}, {15'h0000, active_low});
   endtask : ret
   task automatic t_reset;
      chk("primary", 16'h0000, {8'h00, pe});
      chk("level", 16'h0000, {8'h00, ls});
      wr(2, 8'hff);
      chk("secondary", 16'h0003, {8'h00, se});
      clk_en = 1'b0;
      wr(0, 8'h81);
      chk("frozen primary", 16'h0000, {8'h00, pe});
      clk_en = 1'b1;
   endtask : t_reset
   task automatic t_gate;
      wr(2, 8'h00);
      rq = 12'hfff;
      wr(0, 8'h7f);
      repeat (3) @(negedge ref_clk);
      chk("gate closed", 16'h0000, {15'h0000, irq_req});
      wr(0, 8'h80);
      repeat (3) @(negedge ref_clk);
      chk("all disabled", 16'h0000, {15'h0000, irq_req});
      rq = 12'h000;
   endtask : t_gate
   task automatic t_poll;
      logic [15:0] v[9] = '{16'h0043, 16'h0003, 16'h0033, 16'h000b, 16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b};
      logic [11:0] m[9] = '{12'h001, 12'h002, 12'h008, 12'h010, 12'h004, 12'h020, 12'h300, 12'hc00, 12'h0c0};
      wr(2, 8'h03);
      wr(0, 8'hff);
      // One half of each shared pair only, so the OR is exercised
      rq = 12'habf;
      for (int k = 0; k < 9; k++) begin
         serve(v[k], m[k], 1'b0, 4'(k));
         ret(1'b0, 1'b0);
      end
   endtask : t_poll
   task automatic t_preempt;
      wr(1, 8'h04);
      rq = 12'h002;
      serve(16'h0003, 12'h000, 1'b0, 4'h1);
      rq = 12'h016;
      serve(16'h0013, 12'h004, 1'b1, 4'h4);
      repeat (3) @(negedge ref_clk);
      chk("held while nested", 16'h0000, {15'h0000, irq_req});
      ret(1'b0, 1'b1);
      chk("held under low", 16'h0000, {15'h0000, irq_req});
      rq = rq & ~12'h002;
      ret(1'b0, 1'b0);
      serve(16'h000b, 12'h010, 1'b0, 4'h3);
      ret(1'b0, 1'b0);
   endtask : t_preempt
   task automatic t_simul;
      wr(1, 8'h20);
      ack_wait = 4'h3;
      rq = 12'h041;
      serve(16'h002b, 12'h040, 1'b1, 4'h8);
      ret(1'b0, 1'b0);
      serve(16'h0043, 12'h001, 1'b0, 4'h0);
      ret(1'b0, 1'b0);
   endtask : t_simul
   initial begin
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      t_reset();
      t_gate();
      t_poll();
      t_preempt();
      t_simul();
      give_verdict();
   end
endmodule : two_level_interrupt_ctrl_test
bind two_level_interrupt_ctrl irq_ctrl_props u_irq_ctrl_props (.*);
